// file: rtl/rft_cfg.svh
// Constants for the frequency trim block: offsets, field positions, reset values, timing.
`ifndef RFT_CFG_SVH
`define RFT_CFG_SVH

// ***************************************************************
// Register map
// ***************************************************************
`define RFT_ADDR_COARSE 8'h10
`define RFT_ADDR_FINE 8'h12
`define RFT_READ_UNMAPPED 8'h00

// ***************************************************************
// Field layout and reset values
// ***************************************************************
`define RFT_COARSE_W 5
`define RFT_COARSE_SIGN 4
`define RFT_COARSE_PAD 3'h0
`define RFT_FINE_W 8
`define RFT_FINE_SIGN 7
`define RFT_COARSE_RST 5'h00
`define RFT_FINE_RST 8'h00

// ***************************************************************
// Timing
// ***************************************************************
`define RFT_CLK_HZ 25000000
`define RFT_SEC_TIME_S 1
`define RFT_FINE_SECS 8
`define RFT_FINE_LAST 3'h7
`define RFT_CNT_W 26

`endif

// file: rtl/rft_pkg.sv
// Types shared by the frequency trim block.
package rft_pkg;

  `include "rft_cfg.svh"

  // Register access strobe bundle from the serial interface logic
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } rft_regbus_t;

  // Daily correction sequencer modes
  typedef enum logic [3:0] {
    RFT_IDLE = 4'b0001,
    RFT_DROP = 4'b0010,
    RFT_GAP = 4'b0100,
    RFT_INSERT = 4'b1000
  } rft_mode_t;

  // Whole state of the top module
  typedef struct packed {
    rft_mode_t mode;
    logic [`RFT_COARSE_W-1:0] coarse;
    logic [`RFT_FINE_W-1:0] fine;
    logic [7:0] rdData;
    logic [3:0] pend;
    logic dayTwo;
    logic doneToday;
    logic incPulse;
  } rft_top_state_t;

  // Whole state of the fine timebase
  typedef struct packed {
    logic [`RFT_CNT_W-1:0] cnt;
    logic [2:0] acc;
    logic [2:0] idx;
    logic [`RFT_FINE_W-1:0] code;
    logic tick;
  } rft_fine_state_t;

endpackage

// file: rtl/rft_fine_trim.sv
// Sigma-delta trimmed one-second timebase over an eight-second interval.
`timescale 1ns/100ps
`default_nettype none

`include "rft_cfg.svh"

module rft_fine_trim #(
  parameter int SEC_CYCLES = 25000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Trim code from the register file
  input wire logic [7:0] fineCode,
  // Trimmed one-second pulse
  output logic secTick
);
  import rft_pkg::*;

  localparam logic [`RFT_CNT_W-1:0] BASE = `RFT_CNT_W'(SEC_CYCLES);

  rft_fine_state_t st_r;
  rft_fine_state_t st_nxt;

  logic [`RFT_FINE_W-1:0] useCode;
  logic [2:0] useAcc;
  logic useNeg;
  logic [7:0] mag;
  logic [8:0] sum;
  logic [`RFT_CNT_W-1:0] adj;
  logic [`RFT_CNT_W-1:0] period;

  // Next second's length from the sigma-delta accumulator
  always_comb begin
    useCode = (st_r.idx == `RFT_FINE_LAST) ? fineCode : st_r.code;
    useAcc = (st_r.idx == `RFT_FINE_LAST) ? 3'h0 : st_r.acc;
    useNeg = useCode[`RFT_FINE_SIGN];
    mag = useNeg ? 8'(-useCode) : useCode;
    sum = {1'b0, mag} + {6'h00, useAcc};
    adj = `RFT_CNT_W'(sum[8:3]);
    // Positive code shortens the second, negative lengthens it
    period = useNeg ? (BASE + adj) : (BASE - adj);
  end

  // Down counter; a whole code is held for each eight-second interval
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == '0) begin
      st_nxt.tick = 1'b1;
      st_nxt.cnt = period - `RFT_CNT_W'(1);
      st_nxt.acc = sum[2:0];
      st_nxt.idx = st_r.idx + 3'h1;
      st_nxt.code = useCode;
    end else begin
      st_nxt.cnt = st_r.cnt - `RFT_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{cnt: BASE - `RFT_CNT_W'(1), acc: 3'h0, idx: `RFT_FINE_LAST,
                code: `RFT_FINE_RST, tick: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign secTick = st_r.tick;

endmodule

`default_nettype wire

// file: rtl/rft_top.sv
// Frequency trim block: trim registers, fine timebase and daily coarse correction.
//
// Summary of operation
// - The coarse code is bits 4..0 of the coarse register, signed, bit 4 the sign.
// - Writes to bits 7..5 of the coarse register are dropped and they read as zero.
// - A coarse code of size n corrects floor(n/2) s on day one and ceil(n/2) s on day two.
// - Day one and day two corrections alternate until the coarse register is next written, even with the same code.
// - The daily correction happens only when the time reads 00:00:30.
// - A negative correction discards that many one-second pulses so the time stands still.
// - The fine trim is a sigma-delta correction over a repeating eight-second interval.
// - The fine code is all eight bits of the fine register at 12h, two's complement.
// - The fine code spans -128 to +127 steps, 80h being the largest negative trim.
// - The coarse register sits at 10h with the code in its low five bits.
// - A positive fine code speeds the timebase up, a negative one slows it down.
`timescale 1ns/100ps
`default_nettype none

`include "rft_cfg.svh"

module rft_top #(
  parameter int SEC_CYCLES = `RFT_CLK_HZ * `RFT_SEC_TIME_S
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register access from the serial interface
  input wire rft_pkg::rft_regbus_t regBus,
  output logic [7:0] regRdData,
  // Time counters
  input wire logic timeAt0030,
  output logic timeIncr,
  // Status
  output logic dayTwo
);
  import rft_pkg::*;

  rft_top_state_t st_r;
  rft_top_state_t st_nxt;

  logic secTick;
  logic [4:0] coarseMag;
  logic [3:0] dayOneSecs;
  logic [3:0] dayTwoSecs;
  logic [3:0] corrSecs;
  logic coarseNeg;

  // ***************************************************************
  // Fine timebase
  // ***************************************************************
  rft_fine_trim #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_fine (
    .clk(clk),
    .sys_rst(sys_rst),
    .fineCode(st_r.fine),
    .secTick(secTick)
  );

  // ***************************************************************
  // Coarse correction size
  // ***************************************************************
  // Code 10000 gives magnitude 16, which still fits five bits unsigned
  always_comb begin
    coarseNeg = st_r.coarse[`RFT_COARSE_SIGN];
    coarseMag = coarseNeg ? 5'(-st_r.coarse) : st_r.coarse;
    dayOneSecs = coarseMag[4:1];
    dayTwoSecs = 4'(coarseMag - {1'b0, coarseMag[4:1]});
    corrSecs = st_r.dayTwo ? dayTwoSecs : dayOneSecs;
  end

  // ***************************************************************
  // Register file and correction sequencer
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.incPulse = 1'b0;

    // Register writes; upper coarse bits are simply not stored
    if (regBus.wrEn) begin
      if (regBus.addr == `RFT_ADDR_COARSE) begin
        st_nxt.coarse = regBus.wrData[`RFT_COARSE_W-1:0];
      end
      if (regBus.addr == `RFT_ADDR_FINE) begin
        st_nxt.fine = regBus.wrData;
      end
    end

    // Register reads are captured one cycle after the strobe
    if (regBus.rdEn) begin
      if (regBus.addr == `RFT_ADDR_COARSE) begin
        st_nxt.rdData = {`RFT_COARSE_PAD, st_r.coarse};
      end else if (regBus.addr == `RFT_ADDR_FINE) begin
        st_nxt.rdData = st_r.fine;
      end else begin
        st_nxt.rdData = `RFT_READ_UNMAPPED;
      end
    end

    unique case (st_r.mode)
      RFT_IDLE: begin
        // Leaving 00:00:30 rearms the once-a-day correction
        if (!timeAt0030) begin
          st_nxt.doneToday = 1'b0;
        end
        if (secTick && timeAt0030 && !st_r.doneToday) begin
          st_nxt.doneToday = 1'b1;
          st_nxt.dayTwo = !st_r.dayTwo;
          if (corrSecs == 4'h0) begin
            st_nxt.incPulse = 1'b1;
          end else if (coarseNeg) begin
            // This pulse is the first one thrown away
            st_nxt.pend = corrSecs - 4'h1;
            st_nxt.mode = (corrSecs == 4'h1) ? RFT_IDLE : RFT_DROP;
          end else begin
            // Normal increment now, extra ones follow with a gap
            st_nxt.incPulse = 1'b1;
            st_nxt.pend = corrSecs;
            st_nxt.mode = RFT_GAP;
          end
        end else begin
          st_nxt.incPulse = secTick;
        end
      end
      RFT_DROP: begin
        // Time counters stand still while pulses are swallowed
        if (secTick) begin
          st_nxt.pend = st_r.pend - 4'h1;
          if (st_r.pend == 4'h1) begin
            st_nxt.mode = RFT_IDLE;
          end
        end
      end
      RFT_GAP: begin
        // One idle cycle lets the counters settle their carries
        st_nxt.mode = RFT_INSERT;
      end
      RFT_INSERT: begin
        st_nxt.incPulse = 1'b1;
        st_nxt.pend = st_r.pend - 4'h1;
        st_nxt.mode = (st_r.pend == 4'h1) ? RFT_IDLE : RFT_GAP;
      end
    endcase

    // A new coarse code restarts the pair at day one
    if (regBus.wrEn && regBus.addr == `RFT_ADDR_COARSE) begin
      st_nxt.dayTwo = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{mode: RFT_IDLE, coarse: `RFT_COARSE_RST, fine: `RFT_FINE_RST,
                rdData: `RFT_READ_UNMAPPED, pend: 4'h0, dayTwo: 1'b0,
                doneToday: 1'b0, incPulse: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign regRdData = st_r.rdData;
  assign timeIncr = st_r.incPulse;
  assign dayTwo = st_r.dayTwo;

endmodule

`default_nettype wire

// file: dv/rft_top_properties.sv
// Port checker of the frequency trim block
`timescale 1ns/100ps
`default_nettype none
module rft_top_properties #(parameter int SEC_CYCLES = 200) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus
  input wire rft_pkg::rft_regbus_t regBus,
  input wire logic [7:0] regRdData,
  // Time counters
  input wire logic timeAt0030,
  input wire logic timeIncr,
  input wire logic dayTwo
);
  import rft_pkg::*;
  logic [4:0] coarse_r;
  logic [7:0] fine_r;
  int gap_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of written fields, cycles since the last increment
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coarse_r <= 5'h00;
      fine_r <= 8'h00;
      gap_r <= 0;
    end else begin
      if (regBus.wrEn && regBus.addr == 8'h10) coarse_r <= regBus.wrData[4:0];
      if (regBus.wrEn && regBus.addr == 8'h12) fine_r <= regBus.wrData;
      gap_r <= timeIncr ? 0 : gap_r + 1;
    end
  end
  sequence sWrC;
    regBus.wrEn && regBus.addr == 8'h10;
  endsequence
  sequence sRd(a);
    regBus.rdEn && regBus.addr == a;
  endsequence
  // Read answers, old value if written in the same cycle
  chk_coarse_read:
    assert property (sRd(8'h10) |=> regRdData == {3'h0, $past(coarse_r)}) else $error("coarse");
  chk_fine_read:
    assert property (sRd(8'h12) |=> regRdData == $past(fine_r)) else $error("fine");
  chk_unmapped_zero:
    assert property (regBus.rdEn && regBus.addr != 8'h10 && regBus.addr != 8'h12
      |=> regRdData == 8'h00) else $error("unmapped");
  chk_read_hold:
    assert property (!regBus.rdEn |=> $stable(regRdData)) else $error("hold");
  // Extra increments are single pulses
  chk_incr_pulse:
    assert property (timeIncr |=> !timeIncr) else $error("pulse");
  chk_write_restart:
    assert property (sWrC |=> !dayTwo) else $error("restart");
  chk_day_cause:
    assert property ($changed(dayTwo) |-> $past(timeAt0030) || $past(regBus.wrEn))
      else $error("day flag");
  // Fine trim moves a second by at most 16 cycles
  chk_sec_short:
    assert property (timeIncr && !timeAt0030 |-> gap_r >= SEC_CYCLES - 17) else $error("short");
  chk_sec_long:
    assert property (gap_r > SEC_CYCLES + 16 |-> timeAt0030) else $error("long");
endmodule
bind rft_top rft_top_properties #(.SEC_CYCLES(SEC_CYCLES)) chk (.clk(clk), .sys_rst(sys_rst),
  .regBus(regBus), .regRdData(regRdData), .timeAt0030(timeAt0030), .timeIncr(timeIncr),
  .dayTwo(dayTwo));
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench of the frequency trim block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rft_pkg::*;
  localparam int SC = 40;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic at30 = 1'b0;
  logic done = 1'b0;
  logic rdV = 1'b0;
  rft_regbus_t bus = '0;
  logic [7:0] rdData;
  logic incr;
  logic day2;
  int fail_count = 0;
  int check_count = 0;
  int incN = 0;
  logic [31:0] seen;
  logic [31:0] expQ[$];
  // 1f covers a zero day-one step and a single dropped second on day two
  logic [4:0] cs[6] = '{5'h03, 5'h1b, 5'h0f, 5'h10, 5'h01, 5'h1f};
  logic [7:0] fs[4] = '{8'h7f, 8'h80, 8'h00, 8'h05};
  time t0;
  rft_top #(.SEC_CYCLES(SC)) dut (.clk(clk), .sys_rst(sys_rst), .regBus(bus),
    .regRdData(rdData), .timeAt0030(at30), .timeIncr(incr), .dayTwo(day2));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  task automatic check(logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %0h exp %0h", $time, s, e);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Oldest note is taken when a read answer or a window result lands
  always @(posedge clk) begin
    rdV <= bus.rdEn;
    if (incr === 1'b1) incN <= incN + 1;
    if (rdV) check(32'(rdData), expQ.pop_front());
    if (done) check(seen, expQ.pop_front());
  end
  // One strobe cycle, always entered one edge after the last
  task automatic busOp(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk) bus <= '{w, !w, a, d};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rdReg(logic [7:0] a, logic [7:0] e);
    expQ.push_back(32'(e));
    busOp(1'b0, a, 8'h00);
  endtask
  task automatic post(logic [31:0] s, logic [31:0] e);
    expQ.push_back(e);
    seen = s;
    done <= 1'b1;
    @(posedge clk) done <= 1'b0;
  endtask
  // Bounded wait for the next increment pulse
  task automatic waitInc;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 4 * SC) begin
        check(0, 1);
        close_out();
      end
    end while (incr !== 1'b1);
  endtask
  function automatic int corr(logic [4:0] c, bit two);
    int m;
    m = c[4] ? 32 - int'(c) : int'(c);
    m = two ? (m + 1) / 2 : m / 2;
    return c[4] ? -m : m;
  endfunction
  // Ten and a half seconds at 00:00:30; pulses counted, day flag sampled at the end
  task automatic visit(logic [4:0] c, bit two);
    int c0;
    waitInc();
    at30 <= 1'b1;
    @(posedge clk) c0 = incN;
    repeat (10 * SC + SC / 2) @(posedge clk);
    at30 <= 1'b0;
    post({day2, 8'(incN - c0)}, {~two, 8'(10 + corr(c, two))});
    repeat (SC) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h9156));
    cs[4] = 5'($urandom) | 5'h01;
    fs[3] = 8'($urandom);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rdReg(8'h10, 8'h00);
    rdReg(8'h12, 8'h00);
    busOp(1'b1, 8'h11, 8'hff);
    busOp(1'b1, 8'h10, 8'hff);
    rdReg(8'h10, 8'h1f);
    rdReg(8'h11, 8'h00);
    // Pad bits written high must never stick
    foreach (cs[i]) begin
      busOp(1'b1, 8'h10, {3'h5, cs[i]});
      rdReg(8'h10, {3'h0, cs[i]});
      visit(cs[i], 1'b0);
      visit(cs[i], 1'b1);
      visit(cs[i], 1'b0);
    end
    // Any eight seconds in steady state move by exactly the code
    foreach (fs[i]) begin
      busOp(1'b1, 8'h12, fs[i]);
      rdReg(8'h12, fs[i]);
      repeat (9) waitInc();
      t0 = $time;
      repeat (8) waitInc();
      post(32'(($time - t0) / 40), 32'(8 * SC - $signed(fs[i])));
      repeat (2) @(posedge clk);
    end
    close_out();
  end
endmodule
`default_nettype wire
